// *** hw/apec_top.v ***
`timescale 1ns/1ps
`include "apec_defines.vh"
// Functional notes
// [RULE1] two protection comparators per amplifier, each output readable in status
// [RULE2] fast comparator threshold is an 8-bit DAC code, full scale 2.5V
// [RULE3] limit comparator threshold is a 10-bit DAC code, full scale 2.5V
// [RULE4] per-comparator mask lets a trip raise the main interrupt or not
// [RULE5] two more masks per comparator gate protect events one and two
// [RULE6] both protect events go straight to the driver protection logic
// [RULE7] ten front-end pins, each digital input or open-drain output
// [RULE8] each pin ties to a software data bit or a digital matrix line
// [RULE9] per-pin polarity, active high after reset, active low when set
// [RULE10] pins six to nine raise second interrupt on unmasked rise or fall
// [RULE11] enabled push button reports press, allows hibernate, wakes from it
// [RULE12] button held low over 8s in normal operation resets the controller
// [RULE13] ADC pre-mux picks one of 16 sources, direct or sequencer-stepped
// [RULE14] automatic scan skips sources whose scan mask bit is set
// [RULE15] seven bidirectional digital matrix lines for pins and comparators
// [RULE16] buffer output source select plus input swap control
// [RULE17] general comparator edge masks for second interrupt, optionally into event one
// [RULE18] driver logic uses event one to disable low, high or both groups
// [RULE19] events and main interrupt are OR of unmasked comparator outputs
// [RULE20] inputs synchronised before edge detection, edges held until cleared
module apec_top #(
    parameter [31:0] LONG_PRESS_CYCLES = `APEC_LONG_PRESS_MS * `APEC_CLK_KHZ
) (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire [7:0] paddr_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    input wire [2:0] fast_protect_in,
    input wire [2:0] limit_protect_in,
    output reg [7:0] fast_protect_dac_out,
    output reg [9:0] limit_protect_dac_out,
    output reg main_irq_out,
    output reg second_irq_out,
    output reg protect_event_one_out,
    output reg protect_event_two_out,
    input wire [9:0] front_end_io_pin_in,
    output reg [9:0] front_end_io_pin_out,
    output reg [9:0] front_end_io_pin_oe_out,
    input wire [6:0] digital_route_matrix_in,
    output reg [6:0] digital_route_matrix_out,
    output reg [6:0] digital_route_matrix_oe_out,
    input wire [3:0] general_comparator_in,
    input wire push_button_in,
    output reg hibernate_out,
    output reg wake_out,
    output reg mcu_reset_out,
    input wire adc_step_in,
    output reg [3:0] adc_mux_sel_out,
    output reg [3:0] buffered_out_sel_out,
    output reg buffered_out_swap_out
);

function sel_hit;
    input [2:0] sel;
    input [2:0] line;
    begin
        sel_hit = (sel == line);
    end
endfunction

function [3:0] next_src;
    input [3:0] cur;
    input [15:0] mask;
    integer i;
    reg found;
    reg [3:0] c;
    begin
        next_src = cur;
        found = 1'b0;
        c = cur;
        for (i = 1; i < 16; i = i + 1) begin
            c = cur + i[3:0];
            if (!found && !mask[c]) begin
                next_src = c;
                found = 1'b1;
            end
        end
    end
endfunction

reg [`APEC_S_W-1:0] sync1;
reg [`APEC_S_W-1:0] sync2;
reg [`APEC_S_W-1:0] sync_prev;
reg [2:0] ctrl;
reg [5:0] main_mask;
reg [5:0] ev1_mask;
reg [5:0] ev2_mask;
reg [9:0] io_dir;
reg [9:0] io_route;
reg [9:0] io_pol;
reg [9:0] io_data;
reg [29:0] io_sel;
reg [19:0] gcmp_cfg;
reg [15:0] edge_mask;
reg [16:0] edge_pend;
reg [15:0] scan_mask;
reg adc_auto;
reg [31:0] press_cnt;
reg [31:0] next_rdata;
reg next_err;

wire [5:0] trip_now = sync2[5:0];
wire btn_now = sync2[`APEC_S_BTN];
wire btn_fall = sync_prev[`APEC_S_BTN] & ~btn_now;
wire [3:0] io_hi_now = sync2[`APEC_S_IO+9:`APEC_S_IO+6];
wire [3:0] io_hi_prev = sync_prev[`APEC_S_IO+9:`APEC_S_IO+6];
wire [3:0] gc_now = sync2[`APEC_S_GCMP+3:`APEC_S_GCMP];
wire [3:0] gc_prev = sync_prev[`APEC_S_GCMP+3:`APEC_S_GCMP];
wire [15:0] edge_seen = {gc_prev & ~gc_now, ~gc_prev & gc_now, io_hi_prev & ~io_hi_now, ~io_hi_prev & io_hi_now};
wire [9:0] io_logic_in = sync2[`APEC_S_IO+9:`APEC_S_IO] ^ io_pol; // [RULE9]
wire [3:0] gc_logic = gc_now ^ gcmp_cfg[3:0];
wire irq2_any = |edge_pend[15:0];
wire setup = psel_in & ~penable_in;
wire wr = psel_in & penable_in & pready_out & pwrite_in;
wire [31:0] wd = pwdata_in;

// matrix line drivers and pin outputs
reg [6:0] next_line_oe;
reg [6:0] next_line_val;
reg [9:0] next_pin_oe;
integer k;
integer p;
always @* begin
    next_line_oe = 7'h00;
    next_line_val = 7'h00;
    next_pin_oe = 10'h000;
    for (k = 0; k < 7; k = k + 1) begin
        for (p = 0; p < 10; p = p + 1) begin
            if (!io_dir[p] && io_route[p] && sel_hit(io_sel[3*p +: 3], k[2:0])) begin // [RULE15]
                next_line_oe[k] = 1'b1;
                next_line_val[k] = next_line_val[k] | io_logic_in[p];
            end
        end
        for (p = 0; p < 4; p = p + 1) begin
            if (gcmp_cfg[4+p] && sel_hit(gcmp_cfg[8+3*p +: 3], k[2:0])) begin // [RULE15]
                next_line_oe[k] = 1'b1;
                next_line_val[k] = next_line_val[k] | gc_logic[p];
            end
        end
    end
    for (p = 0; p < 10; p = p + 1) begin
        // open drain: only ever pulls low, so a driven pin means logical value low after polarity
        if (io_dir[p]) begin // [RULE7]
            if (io_route[p]) begin
                next_pin_oe[p] = ~(digital_route_matrix_in[io_sel[3*p +: 3]] ^ io_pol[p]); // [RULE8]
            end else begin
                next_pin_oe[p] = ~(io_data[p] ^ io_pol[p]); // [RULE8]
            end
            if (io_sel[3*p +: 3] == `APEC_SEL_NONE && io_route[p]) begin
                next_pin_oe[p] = 1'b0;
            end
        end
    end
end

always @* begin
    next_err = 1'b0;
    case (paddr_in)
        `APEC_CTRL: next_rdata = {29'h0, ctrl[2], hibernate_out, ctrl[0]};
        `APEC_STATUS: next_rdata = {24'h0, hibernate_out, btn_now, trip_now}; // [RULE1]
        `APEC_MAIN_MASK: next_rdata = {26'h0, main_mask};
        `APEC_EV1_MASK: next_rdata = {26'h0, ev1_mask};
        `APEC_EV2_MASK: next_rdata = {26'h0, ev2_mask};
        `APEC_DAC: next_rdata = {6'h0, limit_protect_dac_out, 8'h0, fast_protect_dac_out};
        `APEC_IO_CFG: next_rdata = {6'h0, io_route, 6'h0, io_dir};
        `APEC_IO_POL: next_rdata = {6'h0, io_data, 6'h0, io_pol};
        `APEC_IO_IN: next_rdata = {22'h0, io_logic_in};
        `APEC_IO_SEL: next_rdata = {2'h0, io_sel};
        `APEC_GCMP_CFG: next_rdata = {12'h0, gcmp_cfg};
        `APEC_EDGE_MASK: next_rdata = {16'h0, edge_mask};
        `APEC_EDGE_PEND: next_rdata = {15'h0, edge_pend};
        `APEC_ADC_MUX: next_rdata = {scan_mask, 11'h0, adc_auto, adc_mux_sel_out};
        `APEC_BUF_CFG: next_rdata = {27'h0, buffered_out_swap_out, buffered_out_sel_out};
        default: begin
            next_rdata = `APEC_RST32;
            next_err = 1'b1;
        end
    endcase
end

always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        sync1 <= {`APEC_S_W{1'b0}};
        sync2 <= {`APEC_S_W{1'b0}};
        sync_prev <= {`APEC_S_W{1'b0}};
        prdata_out <= `APEC_RST32;
        pready_out <= 1'b0;
        pslverr_out <= 1'b0;
        ctrl <= 3'h0;
        main_mask <= 6'h00;
        ev1_mask <= 6'h00;
        ev2_mask <= 6'h00;
        fast_protect_dac_out <= 8'h00;
        limit_protect_dac_out <= 10'h000;
        io_dir <= 10'h000;
        io_route <= 10'h000;
        io_pol <= 10'h000;
        io_data <= 10'h000;
        io_sel <= 30'h3FFF_FFFF;
        gcmp_cfg <= 20'hFFF00;
        edge_mask <= 16'h0000;
        edge_pend <= 17'h00000;
        scan_mask <= 16'h0000;
        adc_auto <= 1'b0;
        adc_mux_sel_out <= 4'h0;
        buffered_out_sel_out <= 4'h0;
        buffered_out_swap_out <= 1'b0;
        press_cnt <= `APEC_RST32;
        hibernate_out <= 1'b0;
        wake_out <= 1'b0;
        mcu_reset_out <= 1'b0;
        main_irq_out <= 1'b0;
        second_irq_out <= 1'b0;
        protect_event_one_out <= 1'b0;
        protect_event_two_out <= 1'b0;
        front_end_io_pin_out <= 10'h000;
        front_end_io_pin_oe_out <= 10'h000;
        digital_route_matrix_out <= 7'h00;
        digital_route_matrix_oe_out <= 7'h00;
    end else begin
        // pins and pushbutton are sampled here before any edge logic sees them
        sync1 <= {general_comparator_in, push_button_in, front_end_io_pin_in, limit_protect_in, fast_protect_in}; // [RULE20]
        sync2 <= sync1;
        sync_prev <= sync2;
        // no wait states: pready rises for the access phase only
        pready_out <= setup;
        // error flag stands for the access cycle only, read data holds until the next setup
        pslverr_out <= setup & next_err;
        if (setup) begin
            prdata_out <= next_rdata;
        end
        if (wr) begin
            case (paddr_in)
                `APEC_CTRL: begin
                    ctrl[`APEC_CTRL_BTN_EN] <= wd[`APEC_CTRL_BTN_EN];
                    ctrl[`APEC_CTRL_IRQ2_EV1] <= wd[`APEC_CTRL_IRQ2_EV1]; // [RULE17]
                end
                `APEC_MAIN_MASK: main_mask <= wd[5:0]; // [RULE4]
                `APEC_EV1_MASK: ev1_mask <= wd[5:0]; // [RULE5]
                `APEC_EV2_MASK: ev2_mask <= wd[5:0]; // [RULE5]
                `APEC_DAC: begin
                    fast_protect_dac_out <= wd[7:0]; // [RULE2]
                    limit_protect_dac_out <= wd[`APEC_DAC_LIMIT_LSB +: 10]; // [RULE3]
                end
                `APEC_IO_CFG: begin
                    io_dir <= wd[9:0]; // [RULE7]
                    io_route <= wd[`APEC_HI_LSB +: 10]; // [RULE8]
                end
                `APEC_IO_POL: begin
                    io_pol <= wd[9:0]; // [RULE9]
                    io_data <= wd[`APEC_HI_LSB +: 10];
                end
                `APEC_IO_SEL: io_sel <= wd[29:0];
                `APEC_GCMP_CFG: gcmp_cfg <= wd[19:0];
                `APEC_EDGE_MASK: edge_mask <= wd[15:0]; // [RULE10] [RULE17]
                `APEC_ADC_MUX: begin
                    scan_mask <= wd[31:16]; // [RULE14]
                    adc_auto <= wd[`APEC_ADC_AUTO];
                end
                `APEC_BUF_CFG: begin
                    buffered_out_sel_out <= wd[3:0]; // [RULE16]
                    buffered_out_swap_out <= wd[`APEC_BUF_SWAP]; // [RULE16]
                end
                default: begin
                end
            endcase
        end
        // new edges win over a write-one-to-clear in the same cycle
        if (wr && paddr_in == `APEC_EDGE_PEND) begin
            edge_pend <= (edge_pend & ~wd[16:0]) | {ctrl[0] & btn_fall, edge_seen & edge_mask}; // [RULE20]
        end else begin
            edge_pend <= edge_pend | {ctrl[0] & btn_fall, edge_seen & edge_mask}; // [RULE10] [RULE11]
        end
        // direct write wins over a sequencer step in the same cycle
        if (wr && paddr_in == `APEC_ADC_MUX) begin
            adc_mux_sel_out <= wd[3:0]; // [RULE13]
        end else if (adc_auto && adc_step_in) begin
            adc_mux_sel_out <= next_src(adc_mux_sel_out, scan_mask); // [RULE13] [RULE14]
        end
        wake_out <= 1'b0;
        if (hibernate_out && btn_fall) begin
            hibernate_out <= 1'b0; // [RULE11]
            wake_out <= 1'b1;
        end else if (wr && paddr_in == `APEC_CTRL && wd[`APEC_CTRL_HIB] && ctrl[0]) begin
            hibernate_out <= 1'b1; // [RULE11]
        end
        // long press counter stops at the limit so it cannot wrap and release
        if (!btn_now && !hibernate_out) begin
            if (press_cnt != LONG_PRESS_CYCLES) begin
                press_cnt <= press_cnt + 32'h0000_0001; // [RULE12]
            end
        end else begin
            press_cnt <= `APEC_RST32;
        end
        mcu_reset_out <= !btn_now && !hibernate_out && press_cnt == LONG_PRESS_CYCLES; // [RULE12]
        main_irq_out <= |(trip_now & main_mask); // [RULE4] [RULE19]
        protect_event_one_out <= |(trip_now & ev1_mask) | (ctrl[2] & irq2_any); // [RULE6] [RULE17] [RULE19]
        protect_event_two_out <= |(trip_now & ev2_mask); // [RULE6] [RULE19]
        second_irq_out <= irq2_any; // [RULE10]
        front_end_io_pin_out <= 10'h000;
        front_end_io_pin_oe_out <= next_pin_oe; // [RULE7]
        digital_route_matrix_out <= next_line_val;
        digital_route_matrix_oe_out <= next_line_oe; // [RULE15]
    end
end

endmodule

// *** inc/apec_defines.vh ***
`ifndef APEC_DEFINES_VH
`define APEC_DEFINES_VH
// register byte offsets
`define APEC_CTRL 8'h00
`define APEC_STATUS 8'h04
`define APEC_MAIN_MASK 8'h08
`define APEC_EV1_MASK 8'h0C
`define APEC_EV2_MASK 8'h10
`define APEC_DAC 8'h14
`define APEC_IO_CFG 8'h18
`define APEC_IO_POL 8'h1C
`define APEC_IO_IN 8'h20
`define APEC_IO_SEL 8'h24
`define APEC_GCMP_CFG 8'h28
`define APEC_EDGE_MASK 8'h2C
`define APEC_EDGE_PEND 8'h30
`define APEC_ADC_MUX 8'h34
`define APEC_BUF_CFG 8'h38
// field positions
`define APEC_CTRL_BTN_EN 0
`define APEC_CTRL_HIB 1
`define APEC_CTRL_IRQ2_EV1 2
`define APEC_DAC_LIMIT_LSB 16
`define APEC_HI_LSB 16
`define APEC_PEND_PRESS 16
`define APEC_ADC_AUTO 4
`define APEC_BUF_SWAP 4
// synchroniser vector positions
`define APEC_S_FAST 0
`define APEC_S_LIMIT 3
`define APEC_S_IO 6
`define APEC_S_BTN 16
`define APEC_S_GCMP 17
`define APEC_S_W 21
// reset values
`define APEC_RST32 32'h0000_0000
`define APEC_SEL_NONE 3'h7
// timing
`define APEC_LONG_PRESS_MS 32'h0000_1F40
`define APEC_CLK_KHZ 32'h0003_D090
`endif

// *** testbench/apec_assertions.sv ***
`timescale 1ns/1ps
module apec_assertions #(
    parameter [31:0] LONG_PRESS_CYCLES = 32'h0000_0014
) (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire pready_out,
    input wire pslverr_out,
    input wire [2:0] fast_protect_in,
    input wire [2:0] limit_protect_in,
    input wire [7:0] fast_protect_dac_out,
    input wire main_irq_out,
    input wire second_irq_out,
    input wire protect_event_two_out,
    input wire [9:0] front_end_io_pin_out,
    input wire push_button_in,
    input wire hibernate_out,
    input wire wake_out,
    input wire mcu_reset_out
);
    // raw low time of the button, so a long press is judged against the real hold
    reg [31:0] low_cnt;
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            low_cnt <= 32'h0000_0000;
        else if (push_button_in)
            low_cnt <= 32'h0000_0000;
        else
            low_cnt <= low_cnt + 32'h0000_0001;
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence apb_setup;
        psel_in && !penable_in;
    endsequence
    sequence wake_step;
        wake_out ##1 !wake_out;
    endsequence
    ready_a: assert property (apb_setup |=> pready_out)
        else $error("no ready after setup");
    slverr_a: assert property (pslverr_out |-> pready_out && psel_in && penable_in)
        else $error("error flag outside access");
    dac_write_a: assert property (!(psel_in && penable_in && pwrite_in) |=> $stable(fast_protect_dac_out))
        else $error("threshold code moved without write");
    irq_quiet_a: assert property ((fast_protect_in == 3'h0 && limit_protect_in == 3'h0) [*5]
        |-> !main_irq_out && !protect_event_two_out) else $error("request with idle comparators");
    wake_pulse_a: assert property (wake_out |-> $past(hibernate_out) ##0 wake_step)
        else $error("bad wake pulse");
    lpress_min_a: assert property ($rose(mcu_reset_out) |-> low_cnt >= LONG_PRESS_CYCLES)
        else $error("reset before long hold");
    release_a: assert property ($rose(push_button_in) |-> ##[1:4] !mcu_reset_out)
        else $error("reset held after release");
    pend_hold_a: assert property ($fell(second_irq_out)
        |-> $past(pwrite_in && penable_in) || $past(pwrite_in && penable_in, 2)) else $error("pending lost");
    od_low_a: assert property (front_end_io_pin_out == 10'h000)
        else $error("pin driven high");
endmodule
bind apec_top apec_assertions #(.LONG_PRESS_CYCLES(LONG_PRESS_CYCLES)) chk_i (.ref_clk_in, .rst_n_in, .psel_in,
    .penable_in, .pwrite_in, .pready_out, .pslverr_out, .fast_protect_in, .limit_protect_in, .fast_protect_dac_out,
    .main_irq_out, .second_irq_out, .protect_event_two_out, .front_end_io_pin_out, .push_button_in, .hibernate_out,
    .wake_out, .mcu_reset_out);

// *** testbench/apec_gate_model.sv ***
`timescale 1ns/1ps
module apec_gate_model (
    input wire clk_in,
    input wire rst_n_in,
    input wire event_in,
    input wire lo_mask_in,
    input wire hi_mask_in,
    output reg lo_off_out,
    output reg hi_off_out
);
    // follows the event each cycle; latching is left to the driver enables
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lo_off_out <= 1'b0;
            hi_off_out <= 1'b0;
        end else begin
            lo_off_out <= event_in & lo_mask_in;
            hi_off_out <= event_in & hi_mask_in;
        end
    end
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`include "apec_defines.vh"
module tb_top;
    reg clk, rst_n, psel, pen, pwr, btn, step, perr_q, hm;
    reg [7:0] pa;
    reg [31:0] pwd, q;
    reg [2:0] fp, lp;
    reg [9:0] pin_drv;
    reg [3:0] gc;
    integer err_total, n_checks, i;
    wire [31:0] prd;
    wire prdy, perr, mirq, sirq, ev1, ev2, hib, wake, mrst, lo_off, hi_off, bswap;
    wire [7:0] fdac;
    wire [9:0] limdac, pout, poe;
    wire [6:0] mout, moe;
    wire [3:0] amux, bsel;
    apec_top #(.LONG_PRESS_CYCLES(32'h0000_0014)) dut (.ref_clk_in(clk), .rst_n_in(rst_n), .paddr_in(pa), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
        .fast_protect_in(fp), .limit_protect_in(lp), .fast_protect_dac_out(fdac), .limit_protect_dac_out(limdac),
        .main_irq_out(mirq), .second_irq_out(sirq), .protect_event_one_out(ev1), .protect_event_two_out(ev2),
        .front_end_io_pin_in(pin_drv & ~poe), .front_end_io_pin_out(pout), .front_end_io_pin_oe_out(poe),
        .digital_route_matrix_in(mout & moe), .digital_route_matrix_out(mout), .digital_route_matrix_oe_out(moe),
        .general_comparator_in(gc), .push_button_in(btn), .hibernate_out(hib), .wake_out(wake),
        .mcu_reset_out(mrst), .adc_step_in(step), .adc_mux_sel_out(amux), .buffered_out_sel_out(bsel),
        .buffered_out_swap_out(bswap));
    apec_gate_model gate (.clk_in(clk), .rst_n_in(rst_n), .event_in(ev1), .lo_mask_in(1'b1), .hi_mask_in(hm),
        .lo_off_out(lo_off), .hi_off_out(hi_off));
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", n_checks, err_total);
            if (err_total == 0 && n_checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task chk(input [31:0] g, input [31:0] e);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("unexpected at %0t: got %h want %h", $time, g, e);
            end
        end
    endtask
    // released at the answer edge; one idle edge follows so back-to-back calls never reassign psel in one step
    task apb(input [7:0] a, input w, input [31:0] d);
        begin
            psel <= 1'b1;
            pen <= 1'b0;
            pa <= a;
            pwr <= w;
            pwd <= d;
            @(posedge clk);
            pen <= 1'b1;
            @(posedge clk);
            while (prdy !== 1'b1) @(posedge clk);
            q = prd;
            perr_q = perr;
            psel <= 1'b0;
            pen <= 1'b0;
            @(posedge clk);
        end
    endtask
    task rd(input [7:0] a, input [31:0] e);
        begin
            apb(a, 1'b0, 32'h0000_0000);
            chk(q, e);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total = err_total + 1;
        end_sim;
    end
    initial begin
        err_total = 0;
        n_checks = 0;
        rst_n = 1'b0;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        pa = 8'h00;
        pwd = 32'h0000_0000;
        btn = 1'b1;
        step = 1'b0;
        hm = 1'b0;
        fp = 3'h0;
        lp = 3'h0;
        pin_drv = 10'h000;
        gc = 4'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(`APEC_IO_SEL, 32'h3FFF_FFFF);
        rd(`APEC_GCMP_CFG, 32'h000F_FF00);
        rd(`APEC_STATUS, 32'h0000_0040);
        rd(8'h3C, 32'h0000_0000);
        chk(perr_q, 32'h0000_0001);
        wr(`APEC_DAC, 32'h03FF_00AB);
        cyc(1);
        chk({fdac, limdac}, 18'h2AFFF);
        for (i = 0; i < 6; i = i + 1) begin
            wr(`APEC_MAIN_MASK, 32'h1 << i);
            wr(`APEC_EV1_MASK, 32'h1 << ((i + 1) % 6));
            wr(`APEC_EV2_MASK, 32'h1 << i);
            {lp, fp} <= 6'h01 << i;
            cyc(6);
            chk({mirq, ev1, ev2}, 3'h5);
            rd(`APEC_STATUS, (32'h1 << i) | 32'h40);
            {lp, fp} <= 6'h00;
        end
        wr(`APEC_EV1_MASK, 32'h3F);
        fp <= 3'h4;
        cyc(6);
        chk({ev1, lo_off, hi_off}, 3'h6);
        hm <= 1'b1;
        cyc(2);
        chk({ev1, lo_off, hi_off}, 3'h7);
        fp <= 3'h0;
        wr(`APEC_IO_CFG, 32'h1);
        wr(`APEC_IO_POL, 32'h1_0000);
        cyc(2);
        chk(poe[0], 1'b0);
        wr(`APEC_IO_POL, 32'h0);
        cyc(2);
        chk(poe[0], 1'b1);
        wr(`APEC_IO_POL, 32'h1);
        cyc(2);
        chk(poe[0], 1'b0);
        pin_drv <= 10'h006;
        cyc(4);
        rd(`APEC_IO_IN, 32'h7);
        wr(`APEC_IO_CFG, 32'h0002_0001);
        wr(`APEC_IO_SEL, 32'h3FFF_FFD7);
        cyc(4);
        chk({moe, mout}, 14'h0204);
        pin_drv <= 10'h000;
        wr(`APEC_IO_SEL, 32'h3FFF_FFFF);
        wr(`APEC_EDGE_MASK, 32'h0111);
        pin_drv <= 10'h040;
        cyc(6);
        rd(`APEC_EDGE_PEND, 32'h1);
        chk(sirq, 1'b1);
        wr(`APEC_CTRL, 32'h4);
        cyc(2);
        chk(ev1, 1'b1);
        pin_drv <= 10'h000;
        cyc(6);
        rd(`APEC_EDGE_PEND, 32'h11);
        wr(`APEC_EDGE_PEND, 32'h11);
        cyc(2);
        chk({sirq, ev1}, 2'h0);
        gc <= 4'h1;
        cyc(6);
        rd(`APEC_EDGE_PEND, 32'h100);
        gc <= 4'h0;
        wr(`APEC_EDGE_PEND, 32'h100);
        wr(`APEC_CTRL, 32'h1);
        wr(`APEC_CTRL, 32'h3);
        cyc(1);
        chk(hib, 1'b1);
        btn <= 1'b0;
        i = 0;
        while (wake !== 1'b1 && i < 10) begin
            @(posedge clk);
            i = i + 1;
        end
        chk(wake, 1'b1);
        @(posedge clk);
        chk(wake, 1'b0);
        btn <= 1'b1;
        rd(`APEC_EDGE_PEND, 32'h1_0000);
        chk(hib, 1'b0);
        wr(`APEC_EDGE_PEND, 32'h1_0000);
        btn <= 1'b0;
        cyc(30);
        chk(mrst, 1'b1);
        btn <= 1'b1;
        cyc(6);
        chk(mrst, 1'b0);
        wr(`APEC_ADC_MUX, 32'h3);
        cyc(1);
        chk(amux, 4'h3);
        wr(`APEC_ADC_MUX, 32'h0030_0013);
        step <= 1'b1;
        @(posedge clk);
        step <= 1'b0;
        cyc(2);
        chk(amux, 4'h6);
        wr(`APEC_GCMP_CFG, 32'h000F_F811);
        wr(`APEC_IO_CFG, 32'h0001_0001);
        wr(`APEC_IO_SEL, 32'h3FFF_FFF8);
        cyc(4);
        chk({moe, mout, poe[0]}, 15'h0103);
        wr(`APEC_BUF_CFG, 32'h15);
        cyc(1);
        chk({bswap, bsel}, 5'h15);
        end_sim;
    end
endmodule
